// File: hdl/ufc_top.sv
// UART with receive FIFO, request-to-send flow control and smart-card
// mode (initial search, automatic NACK, wait and block wait timers).
// Assumes synchronous rxd, an Avalon-MM master and a 25 MHz clk.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module ufc_top
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rxd,
    output logic txd,
    output logic rts_n,
    output logic irq
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Register state
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [BAUD_W-1:0] baud_q, baud_d;
    logic [7:0] wmark_q, wmark_d;
    logic [SCT_W-1:0] sct_q, sct_d;
    logic [IRQ_W-1:0] ien_q, ien_d, ist_q, ist_d, ev, clr;
    logic [31:0] rdata_q, rdata_d, mw;
    logic wreq_q, wreq_d, irq_q, irq_d;
    logic [7:0] addr;
    logic hit, wr, rd, first, sc, t0, t1, ir, search, pen;
    // Baud and ETU timing
    logic [BAUD_W-1:0] div_q, div_d;
    logic [3:0] esub_q, esub_d;
    logic tick, etu_tick;
    // Receive path and FIFO
    logic rx_done, rx_perr, rx_ferr, rx_nerr, rx_en, valid_ts;
    logic [7:0] rx_data;
    logic [7:0] mem_q [FIFO_DEPTH];
    logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [CW-1:0] cnt_q, cnt_d, depth_eff;
    logic [7:0] wm_eff;
    logic store, push, pop, flush, full, found, rts_n_q, rts_n_d;
    // Transmit path
    logic [10:0] frame_q, frame_d;
    logic [3:0] tx_etu_q, tx_etu_d, tx_sub_q, tx_sub_d, tx_lim;
    logic [4:0] nack_q, nack_d;
    logic tx_busy_q, tx_busy_d, txd_q, txd_d, tx_load, tx_done, line;
    // Wait timer
    logic [TMR_W-1:0] tmr_q, tmr_d, tmr_lim;
    logic fired_q, fired_d, expired;

    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] nw,
                                          logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = old;
    endfunction

    // Standard wait period less the one ETU shortfall
    function automatic logic [TMR_W-1:0] wait_limit(logic [7:0] wi,
                                                    logic [7:0] gm);
        wait_limit = WAIT_BASE_ETU * TMR_W'(wi) * TMR_W'(gm)
                     - ETU_SHORTFALL;
    endfunction

    function automatic logic [TMR_W-1:0] block_limit(logic [3:0] bi);
        block_limit = BLOCK_ADD_ETU + (WAIT_BASE_ETU << bi)
                      - ETU_SHORTFALL;
    endfunction

    // Mode decode shared by all groups
    assign addr = 8'(avs_address);
    assign hit = (avs_read | avs_write) && !wreq_q;
    assign wr = avs_write && hit;
    assign rd = avs_read && hit;
    assign first = (avs_read | avs_write) && wreq_q;
    assign sc = (ctrl_q[CB_MODE +: 2] == MODE_SMARTCARD);
    assign ir = (ctrl_q[CB_MODE +: 2] == MODE_INFRARED);
    assign t1 = sc && ctrl_q[CB_T1];
    assign t0 = sc && !ctrl_q[CB_T1];
    assign search = sc && ctrl_q[CB_INIT_SEARCH];
    assign pen = ctrl_q[CB_PARITY_ENABLE] | sc; // Cards always use parity
    assign rx_en = ctrl_q[CB_RX_ENABLE];
    assign tick = (div_q == '0);
    assign etu_tick = tick && (esub_q == 4'hf);

    ufc_rx u_rx (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .tick(tick),
        .en(rx_en),
        .rxd(ir ? ~rxd : rxd),
        .parity_en(pen),
        .parity_odd(ctrl_q[CB_PARITY_ODD]),
        .done(rx_done),
        .data(rx_data),
        .parity_err(rx_perr),
        .frame_err(rx_ferr),
        .noise_err(rx_nerr)
    );

    // Register file and bus answer; effects land on the accept edge
    always_comb begin
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        wmark_d = wmark_q;
        sct_d = sct_q;
        ien_d = ien_q;
        clr = '0;
        rdata_d = rdata_q;
        wreq_d = !first; // Answer one cycle after the request shows
        mw = 32'h0;
        if (wr) begin
            unique case (addr)
                REG_CTRL: begin
                    mw = merge(32'(ctrl_q), avs_writedata, avs_byteenable);
                    ctrl_d = mw[CTRL_W-1:0];
                    if (mw[CB_MODE +: 2] == MODE_POWERLINE) begin
                        ctrl_d[CB_MODE +: 2] = MODE_NORMAL;
                    end
                end
                REG_BAUD: begin
                    mw = merge(32'(baud_q), avs_writedata, avs_byteenable);
                    baud_d = mw[BAUD_W-1:0];
                end
                REG_WMARK: begin
                    mw = merge(32'(wmark_q), avs_writedata, avs_byteenable);
                    wmark_d = mw[7:0];
                end
                REG_SCT: begin
                    mw = merge(32'(sct_q), avs_writedata, avs_byteenable);
                    sct_d = mw[SCT_W-1:0];
                end
                REG_IEN: begin
                    mw = merge(32'(ien_q), avs_writedata, avs_byteenable);
                    ien_d = mw[IRQ_W-1:0];
                end
                REG_ICLR: begin
                    mw = merge(32'h0, avs_writedata, avs_byteenable);
                    clr = mw[IRQ_W-1:0];
                end
                default: ;
            endcase
        end
        // Search ends by itself once the initial character is seen
        if (found) begin
            ctrl_d[CB_INIT_SEARCH] = 1'b0;
        end
        if (first && avs_read) begin
            unique case (addr)
                REG_CTRL: rdata_d = 32'(ctrl_q);
                REG_BAUD: rdata_d = 32'(baud_q);
                REG_WMARK: rdata_d = 32'(wmark_q);
                REG_DATA: rdata_d = (cnt_q != '0) ? 32'(mem_q[rptr_q]) : '0;
                REG_STAT: rdata_d = 32'({rts_n_q, tx_busy_q, 8'(cnt_q)});
                REG_ISTAT: rdata_d = 32'(ist_q);
                REG_IEN: rdata_d = 32'(ien_q);
                REG_SCT: rdata_d = 32'(sct_q);
                default: rdata_d = 32'h0; // Unmapped and write-only read 0
            endcase
        end
        // Sticky events: a set in the clearing cycle survives
        ist_d = (ist_q & ~clr) | ev;
        irq_d = |(ist_q & ien_q);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            baud_q <= BAUD_RST;
            wmark_q <= WMARK_RST;
            sct_q <= SCT_RST;
            ien_q <= IEN_RST;
            ist_q <= '0;
            rdata_q <= 32'h0;
            wreq_q <= 1'b1;
            irq_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            baud_q <= baud_d;
            wmark_q <= wmark_d;
            sct_q <= sct_d;
            ien_q <= ien_d;
            ist_q <= ist_d;
            rdata_q <= rdata_d;
            wreq_q <= wreq_d;
            irq_q <= irq_d;
        end
    end

    // Receive FIFO, events and request-to-send
    always_comb begin
        valid_ts = (rx_data == INIT_DIRECT) || (rx_data == INIT_INVERSE);
        found = rx_done && rx_en && search && valid_ts;
        // Rejected candidates still land here unless NACK mode is on
        store = rx_done && rx_en &&
                !(search && !valid_ts && ctrl_q[CB_AUTOMATIC_NACK_ENABLE]);
        // A disabled FIFO acts as a single holding slot
        depth_eff = ctrl_q[CB_FIFO_ENABLE] ? CW'(FIFO_DEPTH) : CW'(1);
        full = (cnt_q >= depth_eff);
        push = store && !full;
        pop = rd && (addr == REG_DATA) && (cnt_q != '0);
        flush = wr && (addr == REG_FLUSH);
        wptr_d = push ? wptr_q + PW'(1) : wptr_q;
        rptr_d = pop ? rptr_q + PW'(1) : rptr_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        if (flush) begin
            wptr_d = '0;
            rptr_d = '0;
            cnt_d = '0;
        end
        // Count is compared only after the push settles, so the line
        // moves two edges after the stop-bit decision
        wm_eff = ctrl_q[CB_FIFO_ENABLE] ? wmark_q : 8'h01;
        rts_n_d = ctrl_q[CB_RTS_FLOW] && (8'(cnt_q) >= wm_eff);
        ev = '0;
        ev[IRQ_RX_DATA] = push;
        ev[IRQ_PARITY_ERROR_FLAG] = rx_done && rx_en && rx_perr;
        ev[IRQ_FRAMING_ERROR_FLAG] = rx_done && rx_en && rx_ferr;
        ev[IRQ_NOISE_ERROR_FLAG] = rx_done && rx_en && rx_nerr;
        ev[IRQ_FIRST_CHARACTER_FOUND_FLAG] = found;
        ev[IRQ_TRANSMIT_COMPLETE_FLAG] = tx_done;
        ev[IRQ_CHARACTER_WAIT_PERIOD] = expired && !t1;
        ev[IRQ_BLOCK_WAIT_PERIOD] = expired && t1;
        ev[IRQ_OVERRUN] = store && full;
    end

    // Memory has no reset; the count guards stale entries
    always_ff @(posedge clk) begin
        if (ce && !srst && push) begin
            mem_q[wptr_q] <= rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            rts_n_q <= 1'b0;
        end else if (ce) begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            rts_n_q <= rts_n_d;
        end
    end

    // Baud ticks, transmitter, NACK pulse and wait timer
    always_comb begin
        div_d = tick ? baud_q : div_q - BAUD_W'(1);
        esub_d = tick ? esub_q + 4'h1 : esub_q;
        tx_load = wr && (addr == REG_DATA) && ctrl_q[CB_TX_ENABLE] &&
                  !tx_busy_q; // Writes while busy are dropped
        tx_lim = t0 ? TX_DONE_ETU_T0 : (pen ? FRAME_ETU_PARITY : FRAME_ETU);
        frame_d = frame_q;
        tx_busy_d = tx_busy_q;
        tx_etu_d = tx_etu_q;
        tx_sub_d = tx_sub_q;
        tx_done = 1'b0;
        if (tx_load) begin
            frame_d = {1'b1, pen ? ^avs_writedata[7:0] ^
                       ctrl_q[CB_PARITY_ODD] : 1'b1,
                       avs_writedata[7:0], 1'b0};
            tx_busy_d = 1'b1;
            tx_etu_d = 4'h0;
            tx_sub_d = 4'h0;
        end else if (tx_busy_q && tick) begin
            tx_sub_d = tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hf) begin
                tx_etu_d = tx_etu_q + 4'h1;
                // T=0 flags completion at the guard time end
                if (tx_etu_d == tx_lim) begin
                    tx_busy_d = 1'b0;
                    tx_done = 1'b1;
                end
            end
        end
        // Automatic NACK: hold the line low one ETU on a bad parity
        nack_d = nack_q;
        if (rx_done && rx_en && t0 && rx_perr &&
            ctrl_q[CB_AUTOMATIC_NACK_ENABLE]) begin
            nack_d = ETU_TICKS;
        end else if (tick && (nack_q != 5'h0)) begin
            nack_d = nack_q - 5'h1;
        end
        line = 1'b1;
        if (tx_busy_q && (tx_etu_q < FRAME_ETU_PARITY)) begin
            line = frame_q[tx_etu_q];
        end
        line = line & (nack_q == 5'h0);
        txd_d = ir ? ~line : line;
        // Timer restarts on every character edge in either direction
        tmr_lim = t1 ? block_limit(sct_q[SB_BLOCK_WAIT_TIME_INTEGER +: 4])
                     : wait_limit(sct_q[SB_WAIT_TIME_INTEGER +: 8],
                                  sct_q[SB_GUARD_TIME_MULTIPLIER +: 8]);
        tmr_d = tmr_q;
        fired_d = fired_q;
        expired = 1'b0;
        if (!sc || rx_done || tx_done) begin
            tmr_d = '0;
            fired_d = 1'b0;
        end else if (etu_tick && !fired_q) begin
            if (tmr_q == tmr_lim) begin
                expired = 1'b1;
                fired_d = 1'b1;
            end else begin
                tmr_d = tmr_q + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= '0;
            esub_q <= 4'h0;
            frame_q <= 11'h7ff;
            tx_busy_q <= 1'b0;
            tx_etu_q <= 4'h0;
            tx_sub_q <= 4'h0;
            nack_q <= 5'h0;
            txd_q <= 1'b1;
            tmr_q <= '0;
            fired_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            esub_q <= esub_d;
            frame_q <= frame_d;
            tx_busy_q <= tx_busy_d;
            tx_etu_q <= tx_etu_d;
            tx_sub_q <= tx_sub_d;
            nack_q <= nack_d;
            txd_q <= txd_d;
            tmr_q <= tmr_d;
            fired_q <= fired_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wreq_q;
    assign txd = txd_q;
    assign rts_n = rts_n_q;
    assign irq = irq_q;
endmodule

// File: hdl/ufc_pkg.sv
// Constants, field layouts and types of the smart-card capable UART.
// Assumes one clock domain and a 32-bit Avalon-MM register port.
// Operation
// - Negate rts_n when count reaches watermark; with the FIFO disabled the code negates at a count of 1.
// - Negation follows the completely received character.
// - Late negation matters only for deep FIFOs.
// - Error flags still set during initial search.
// - Valid initial character sets found flag.
// - Invalid T=0 initial characters enter FIFO; the code drops them when automatic NACK is enabled.
// - T=0 transmit complete flag at 12 ETUs.
// - Wait periods end one ETU early.
// - Power-line framing mode is not supported.
package ufc_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BAUD = 8'h04;
    localparam logic [7:0] REG_WMARK = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_ISTAT = 8'h14;
    localparam logic [7:0] REG_ICLR = 8'h18;
    localparam logic [7:0] REG_IEN = 8'h1c;
    localparam logic [7:0] REG_SCT = 8'h20;
    localparam logic [7:0] REG_FLUSH = 8'h24;
    // Control register fields
    localparam int CB_RX_ENABLE = 0;
    localparam int CB_TX_ENABLE = 1;
    localparam int CB_MODE = 2;
    localparam int CB_RTS_FLOW = 4;
    localparam int CB_FIFO_ENABLE = 5;
    localparam int CB_INIT_SEARCH = 6;
    localparam int CB_T1 = 7;
    localparam int CB_AUTOMATIC_NACK_ENABLE = 8;
    localparam int CB_PARITY_ENABLE = 9;
    localparam int CB_PARITY_ODD = 10;
    localparam int CTRL_W = 11;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_INFRARED = 2'h1;
    localparam logic [1:0] MODE_SMARTCARD = 2'h2;
    localparam logic [1:0] MODE_POWERLINE = 2'h3;
    // Smart-card timing register fields
    localparam int SB_WAIT_TIME_INTEGER = 0;
    localparam int SB_GUARD_TIME_MULTIPLIER = 8;
    localparam int SB_BLOCK_WAIT_TIME_INTEGER = 16;
    localparam int SCT_W = 20;
    // Interrupt status, clear and enable layout
    localparam int IRQ_RX_DATA = 0;
    localparam int IRQ_PARITY_ERROR_FLAG = 1;
    localparam int IRQ_FRAMING_ERROR_FLAG = 2;
    localparam int IRQ_NOISE_ERROR_FLAG = 3;
    localparam int IRQ_FIRST_CHARACTER_FOUND_FLAG = 4;
    localparam int IRQ_TRANSMIT_COMPLETE_FLAG = 5;
    localparam int IRQ_CHARACTER_WAIT_PERIOD = 6;
    localparam int IRQ_BLOCK_WAIT_PERIOD = 7;
    localparam int IRQ_OVERRUN = 8;
    localparam int IRQ_W = 9;
    // Status register fields
    localparam int STB_COUNT = 0;
    localparam int STB_TX_BUSY = 8;
    localparam int STB_RTS_N = 9;
    // Reset values
    localparam int BAUD_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam logic [BAUD_W-1:0] BAUD_RST = 16'h000d;
    localparam logic [7:0] WMARK_RST = 8'h01;
    localparam logic [SCT_W-1:0] SCT_RST = 20'h4010a;
    localparam logic [IRQ_W-1:0] IEN_RST = 9'h000;
    // Timing, in sample ticks and elementary time units
    localparam int TMR_W = 27;
    localparam logic [4:0] ETU_TICKS = 5'h10;
    localparam logic [3:0] SAMPLE_MID = 4'h9;
    localparam logic [3:0] TX_DONE_ETU_T0 = 4'hc;
    localparam logic [3:0] FRAME_ETU = 4'ha;
    localparam logic [3:0] FRAME_ETU_PARITY = 4'hb;
    localparam logic [TMR_W-1:0] WAIT_BASE_ETU = 27'h00003c0;
    localparam logic [TMR_W-1:0] BLOCK_ADD_ETU = 27'h000000b;
    localparam logic [TMR_W-1:0] ETU_SHORTFALL = 27'h0000001;
    // Initial characters as sampled lsb first
    localparam logic [7:0] INIT_DIRECT = 8'h3b;
    localparam logic [7:0] INIT_INVERSE = 8'h03;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } ufc_rx_state_t;
endpackage

// File: hdl/ufc_rx.sv
// Receive deserialiser: 16 ticks per bit, majority of three samples.
// Assumes tick is a one-cycle strobe and rxd is synchronous to clk.
`timescale 1ns/100ps
module ufc_rx
    import ufc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic tick,
    input wire logic en,
    input wire logic rxd,
    input wire logic parity_en,
    input wire logic parity_odd,
    output logic done,
    output logic [7:0] data,
    output logic parity_err,
    output logic frame_err,
    output logic noise_err
);
    ufc_rx_state_t st_q, st_d;
    logic [3:0] sub_q, sub_d, bit_q, bit_d;
    logic [7:0] sh_q, sh_d, data_q, data_d;
    logic [1:0] smp_q, smp_d;
    logic nz_q, nz_d, pe_q, pe_d, done_q, done_d;
    logic perr_q, perr_d, ferr_q, ferr_d, nerr_q, nerr_d;
    logic v, nzb, mid;

    function automatic logic maj3(logic a, logic b, logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Bit decisions at mid-bit; stop decision ends the frame early
    always_comb begin
        st_d = st_q;
        sub_d = sub_q;
        bit_d = bit_q;
        sh_d = sh_q;
        smp_d = smp_q;
        nz_d = nz_q;
        pe_d = pe_q;
        done_d = 1'b0;
        data_d = data_q;
        perr_d = perr_q;
        ferr_d = ferr_q;
        nerr_d = nerr_q;
        v = maj3(smp_q[1], smp_q[0], rxd);
        nzb = !((smp_q[1] == rxd) && (smp_q[0] == rxd));
        mid = (sub_q == SAMPLE_MID);
        if (tick) begin
            sub_d = sub_q + 4'h1;
            smp_d = {smp_q[0], rxd};
            unique case (st_q)
                RX_IDLE: begin
                    sub_d = 4'h0;
                    bit_d = 4'h0;
                    nz_d = 1'b0;
                    pe_d = parity_odd;
                    if (en && !rxd) begin
                        st_d = RX_START;
                    end
                end
                RX_START: if (mid) begin
                    nz_d = nzb;
                    st_d = v ? RX_IDLE : RX_DATA; // High start is a glitch
                end
                RX_DATA: if (mid) begin
                    sh_d = {v, sh_q[7:1]};
                    pe_d = pe_q ^ v;
                    nz_d = nz_q | nzb;
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        st_d = parity_en ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY: if (mid) begin
                    pe_d = pe_q ^ v;
                    nz_d = nz_q | nzb;
                    st_d = RX_STOP;
                end
                RX_STOP: if (mid) begin
                    done_d = 1'b1;
                    data_d = sh_q;
                    perr_d = parity_en & pe_q;
                    ferr_d = !v;
                    nerr_d = nz_q | nzb;
                    st_d = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= RX_IDLE;
            sub_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            smp_q <= 2'h3;
            nz_q <= 1'b0;
            pe_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= 8'h00;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            nerr_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            sub_q <= sub_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            smp_q <= smp_d;
            nz_q <= nz_d;
            pe_q <= pe_d;
            done_q <= done_d;
            data_q <= data_d;
            perr_q <= perr_d;
            ferr_q <= ferr_d;
            nerr_q <= nerr_d;
        end
    end

    assign done = done_q;
    assign data = data_q;
    assign parity_err = perr_q;
    assign frame_err = ferr_q;
    assign noise_err = nerr_q;
endmodule

// File: sim/ufc_top_monitor.sv
// Port-level timing checks for the UART top.
// Assumes a bind onto ufc_top; sees only its ports.
`timescale 1ns/100ps
module ufc_top_monitor #(
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic rxd,
    input wire logic txd,
    input wire logic rts_n,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_took;
        !$past(avs_waitrequest, 1) || !$past(avs_waitrequest, 2) ||
        !$past(avs_waitrequest, 3) || !$past(avs_waitrequest, 4);
    endsequence
    // Answer one cycle after a request, for one cycle only
    AST_ANSWER_NEXT: assert property (s_req |=> !avs_waitrequest)
        else $error("bus answer missing");
    AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    AST_NO_SPURIOUS: assert property
        (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    // Reset is checked, so never disabled
    AST_RESET_IDLE: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> avs_waitrequest && txd && !rts_n && !irq)
        else $error("outputs not idle after reset");
    AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    // Stop bit is high, so rxd must have been idle before negation
    AST_RTS_AFTER_STOP: assert property ($rose(rts_n) |->
        $past(rxd, 1) && $past(rxd, 4))
        else $error("rts negated before stop bit");
    AST_RTS_RESUME: assert property ($fell(rts_n) |-> s_took)
        else $error("rts reasserted without a pop");
    AST_IRQ_CLEAR: assert property ($fell(irq) |-> s_took)
        else $error("irq dropped without a bus access");
endmodule

// File: sim/ufc_remote_tx.sv
// Remote serial transmitter driving rxd, one frame per send call.
// Assumes the caller waits for rts_n itself; line idles high.
`timescale 1ns/100ps
module ufc_remote_tx #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    output logic rxd
);
    initial rxd = 1'b1;
    // Start, data lsb first, optional parity, stop, idle gap
    task automatic send(input logic [7:0] b, input logic use_par,
        input logic par);
        logic [10:0] f;
        f = use_par ? {1'b1, par, b, 1'b0} : {2'b11, b, 1'b0};
        for (int i = 0; i < (use_par ? 11 : 10); i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        repeat (BIT_CYC) @(posedge clk);
    endtask
endmodule

// File: sim/tb.sv
// Bench: reset values, flow control, smart-card search, TC and irq.
// Assumes baud divider 0, so one bit lasts 16 clk cycles.
`timescale 1ns/100ps
module tb;
    import ufc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic wreq, txd, rts_n, irq, rxd;
    int n_fail = 0, checks = 0, n0, n1;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h3c};
    logic [31:0] re [5] = '{32'h0, 32'hd, 32'h1, 32'h4010a, 32'h0};
    always #20 clk = ~clk;
    ufc_top u_ufc_top (.clk(clk), .srst(srst), .ce(1'b1), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .rxd(rxd), .txd(txd), .rts_n(rts_n), .irq(irq));
    ufc_remote_tx u_ufc_remote_tx (.clk(clk), .rxd(rxd));
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        addr <= a[5:0];
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            finish_test();
        end
    endtask
    // Bounded wait on rts_n or irq; a timeout ends the run
    task automatic waitfor(input logic use_irq, input logic v, output int n);
        n = 0;
        while ((use_irq ? irq : rts_n) !== v) begin
            @(posedge clk);
            n++;
            if (n > 20000) begin
                n_fail++;
                finish_test();
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 0);
            chk("reset value", re[i], q);
        end
        $display("test reset done");
        bus(1'b1, REG_BAUD, 0);
        bus(1'b1, REG_WMARK, 2);
        bus(1'b1, REG_CTRL, 32'h31);
        u_ufc_remote_tx.send(8'h55, 1'b0, 1'b0);
        bus(1'b0, REG_STAT, 0);
        chk("rts below mark", 32'h1, q);
        u_ufc_remote_tx.send(8'ha6, 1'b0, 1'b0);
        waitfor(1'b0, 1'b1, n0);
        bus(1'b0, REG_STAT, 0);
        chk("rts at mark", 32'h202, q);
        bus(1'b0, REG_DATA, 0);
        chk("first char", 32'h55, q);
        bus(1'b0, REG_STAT, 0);
        chk("rts resumed", 32'h1, q);
        bus(1'b0, REG_DATA, 0);
        chk("second char", 32'ha6, q);
        $display("test flow done");
        // Bad parity byte, then a direct initial byte
        bus(1'b1, REG_CTRL, 32'h269);
        u_ufc_remote_tx.send(8'h11, 1'b1, 1'b1);
        bus(1'b0, REG_ISTAT, 0);
        chk("search error", 32'h2, q & 32'h12);
        u_ufc_remote_tx.send(8'h3b, 1'b1, 1'b1);
        bus(1'b0, REG_ISTAT, 0);
        chk("initial found", 32'h12, q & 32'h12);
        bus(1'b0, REG_STAT, 0);
        chk("invalid kept", 32'h2, q & 32'hff);
        bus(1'b1, REG_FLUSH, 1);
        bus(1'b0, REG_STAT, 0);
        chk("flushed", 32'h0, q & 32'hff);
        bus(1'b1, REG_CTRL, 32'h0c);
        bus(1'b0, REG_CTRL, 0);
        chk("mode 3", 32'h0, q);
        $display("test smart-card done");
        // Normal frame TC at 10 ETU against T=0 at 12 ETU
        bus(1'b1, REG_ICLR, 32'h1ff);
        bus(1'b1, REG_IEN, 32'h20);
        bus(1'b1, REG_CTRL, 32'h02);
        bus(1'b1, REG_DATA, 32'h5a);
        waitfor(1'b1, 1'b1, n0);
        bus(1'b1, REG_ICLR, 32'h20);
        waitfor(1'b1, 1'b0, n1);
        chk("irq cleared", 32'h1, 32'(n1 < 3));
        bus(1'b1, REG_CTRL, 32'h0a);
        bus(1'b1, REG_DATA, 32'h5a);
        waitfor(1'b1, 1'b1, n1);
        chk("tc 12 etu", 32'd32, 32'(n1 - n0));
        bus(1'b1, REG_IEN, 32'h40);
        bus(1'b0, REG_ISTAT, 0);
        chk("sticky tc", 32'h20, q & 32'h20);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, REG_CTRL, 0);
        bus(1'b1, REG_SCT, 32'h40101);
        bus(1'b1, REG_CTRL, 32'h08);
        waitfor(1'b1, 1'b1, n0);
        repeat (16) @(posedge clk);
        chk("wait time", 32'h1, 32'(n0 > 15346 && n0 < 15363));
        $display("test tc done");
        finish_test();
    end
endmodule
bind ufc_top ufc_top_monitor #(.ADDR_W(ADDR_W)) u_ufc_top_monitor (
    .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxd(rxd), .txd(txd), .rts_n(rts_n), .irq(irq));
